// [rtl/eepc_bus_if.sv]
// bus cycle request and completion between the sequencer and strobe engine
`timescale 1ns/1ns
interface eepc_bus_if;
    logic        start;
    logic        is_write;
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        done;
    logic [7:0]  rdata;
    modport master (output start, output is_write, output addr, output wdata,
                    input done, input rdata);
    modport engine (input start, input is_write, input addr, input wdata,
                    output done, output rdata);
endinterface

// [rtl/eepc_host.sv]
// host controller for a parallel page-write eeprom with software protection
`timescale 1ns/1ns
`include "eepc_params.svh"
// Notes on behaviour
// - write needs select and write strobe low with output drive high
// - host loads each next byte within two hundred microseconds
// - with protection on, every page write needs the unlock prefix
// - unlock: aa at 1555, 55 at 0aaa, a0 at 1555, then data
// - unlock writes use ordinary write timing
// - protection takes effect only once a page byte follows the prefix
// - disable: six prefix writes then at least one page byte
module eepc_host
    import eepc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire eepc_op_type req_op,
    input  wire logic [12:0] req_addr,
    input  wire logic [6:0]  req_count,
    input  wire logic [7:0]  wr_byte_data,
    output logic [5:0]       wr_byte_index,
    output logic             wr_byte_take,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             busy,
    output logic             timeout_err,
    output logic             chip_select_n,
    output logic             output_drive_n,
    output logic             write_strobe_n,
    output logic [12:0]      mem_addr,
    output logic [7:0]       data_pins_out,
    output logic             data_pins_oe,
    input  wire logic [7:0]  data_pins_in
);
    typedef enum logic [2:0] {
        EEPC_H_IDLE, EEPC_H_PREFIX, EEPC_H_DATA, EEPC_H_READ, EEPC_H_POLL, EEPC_H_PWAIT
    } eepc_hst_type;

    eepc_bus_if bus ();

    eepc_hst_type st_r, st_nxt;
    eepc_op_type  op_r, op_nxt;
    logic [2:0]   step_r, step_nxt;     // prefix step index
    logic [6:0]   left_r, left_nxt;     // page bytes still to load
    logic [5:0]   idx_r, idx_nxt;
    logic [12:0]  base_r, base_nxt;
    logic [7:0]   last_r, last_nxt;     // last byte loaded, for polling
    logic [23:0]  tmr_r, tmr_nxt;       // gap and programming watchdog
    logic         issued_r, issued_nxt;
    logic [7:0]   rdd_r, rdd_nxt;
    logic         rdv_r, rdv_nxt, err_r, err_nxt;
    logic [12:0]  pfx_addr;
    logic [7:0]   pfx_data;
    logic [2:0]   pfx_len;

    // ************************************************
    // command prefix tables
    // ************************************************
    always_comb begin
        pfx_len  = (op_r == EEPC_OP_PROT_OFF) ? 3'd6 : 3'd3;
        pfx_addr = `EEPC_ADDR_A;
        pfx_data = `EEPC_DATA_AA;
        unique case (step_r)
            3'd0: pfx_data = `EEPC_DATA_AA;
            3'd1: begin pfx_addr = `EEPC_ADDR_B; pfx_data = `EEPC_DATA_55; end
            3'd2: pfx_data = (op_r == EEPC_OP_PROT_OFF) ? `EEPC_DATA_80 : `EEPC_DATA_A0;
            3'd3: pfx_data = `EEPC_DATA_AA;
            3'd4: begin pfx_addr = `EEPC_ADDR_B; pfx_data = `EEPC_DATA_55; end
            3'd5: pfx_data = `EEPC_DATA_20;
            default: pfx_data = `EEPC_DATA_AA;
        endcase
    end

    // ************************************************
    // bus cycle requests
    // ************************************************
    always_comb begin
        bus.start    = 1'b0;
        bus.is_write = 1'b1;
        bus.addr     = pfx_addr;
        bus.wdata    = pfx_data;
        wr_byte_take = 1'b0;
        unique case (st_r)
            EEPC_H_PREFIX: bus.start = !issued_r;
            EEPC_H_DATA: begin
                bus.start    = !issued_r;
                bus.addr     = {base_r[12:6], idx_r};
                bus.wdata    = wr_byte_data;
                wr_byte_take = !issued_r;
            end
            EEPC_H_READ, EEPC_H_POLL: begin
                bus.start    = !issued_r;
                bus.is_write = 1'b0;
                bus.addr     = (st_r == EEPC_H_POLL) ? {base_r[12:6], idx_r} : base_r;
            end
            default: bus.start = 1'b0;
        endcase
    end

    // ************************************************
    // operation sequencer
    // ************************************************
    always_comb begin
        st_nxt     = st_r;
        op_nxt     = op_r;
        step_nxt   = step_r;
        left_nxt   = left_r;
        idx_nxt    = idx_r;
        base_nxt   = base_r;
        last_nxt   = last_r;
        tmr_nxt    = (tmr_r != 24'h000000) ? tmr_r - 24'h000001 : tmr_r;
        issued_nxt = issued_r | bus.start;
        rdd_nxt    = rdd_r;
        rdv_nxt    = 1'b0;
        err_nxt    = err_r;
        unique case (st_r)
            EEPC_H_IDLE: begin
                issued_nxt = 1'b0;
                if (req_valid) begin
                    op_nxt   = req_op;
                    base_nxt = req_addr;
                    idx_nxt  = req_addr[5:0];
                    step_nxt = 3'd0;
                    err_nxt  = 1'b0;
                    // at least one byte so protect changes take effect
                    left_nxt = (req_count == 7'h00) ? 7'h01 : req_count;
                    if (req_count > 7'(`EEPC_PAGE_BYTES))
                        left_nxt = 7'(`EEPC_PAGE_BYTES);
                    unique case (req_op)
                        EEPC_OP_READ:  st_nxt = EEPC_H_READ;
                        EEPC_OP_WRITE: st_nxt = EEPC_H_DATA;
                        default:       st_nxt = EEPC_H_PREFIX;
                    endcase
                end
            end
            EEPC_H_PREFIX: if (bus.done) begin
                issued_nxt = 1'b0;
                tmr_nxt    = 24'(`EEPC_BYTE_GAP_CYC);
                step_nxt   = step_r + 3'd1;
                if (step_r + 3'd1 == pfx_len)
                    st_nxt = EEPC_H_DATA;
            end
            EEPC_H_DATA: if (bus.done) begin
                issued_nxt = 1'b0;
                last_nxt   = bus.wdata;
                // a late byte means the device already closed the page
                if (tmr_r == 24'h000000 && (op_r != EEPC_OP_WRITE || left_r != 7'h00)
                    && step_r != 3'd7 && op_r != EEPC_OP_WRITE)
                    err_nxt = 1'b1;
                tmr_nxt  = 24'(`EEPC_BYTE_GAP_CYC);
                step_nxt = 3'd7;
                left_nxt = left_r - 7'h01;
                if (left_r == 7'h01) begin
                    tmr_nxt = 24'(`EEPC_PROG_CYC);
                    st_nxt  = EEPC_H_POLL;
                end else
                    idx_nxt = idx_r + 6'h01;
            end
            EEPC_H_READ: if (bus.done) begin
                rdd_nxt = bus.rdata;
                rdv_nxt = 1'b1;
                st_nxt  = EEPC_H_IDLE;
            end
            // complement of last byte means programming still running
            EEPC_H_POLL: if (bus.done) begin
                issued_nxt = 1'b0;
                if (bus.rdata == last_r)
                    st_nxt = EEPC_H_IDLE;
                else if (tmr_r == 24'h000000) begin
                    err_nxt = 1'b1;
                    st_nxt  = EEPC_H_IDLE;
                end
            end
            default: st_nxt = EEPC_H_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r     <= EEPC_H_IDLE;
            op_r     <= EEPC_OP_READ;
            step_r   <= 3'd0;
            left_r   <= 7'h00;
            idx_r    <= 6'h00;
            base_r   <= 13'h0000;
            last_r   <= 8'h00;
            tmr_r    <= 24'h000000;
            issued_r <= 1'b0;
            rdd_r    <= 8'h00;
            rdv_r    <= 1'b0;
            err_r    <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            op_r     <= op_nxt;
            step_r   <= step_nxt;
            left_r   <= left_nxt;
            idx_r    <= idx_nxt;
            base_r   <= base_nxt;
            last_r   <= last_nxt;
            tmr_r    <= tmr_nxt;
            issued_r <= issued_nxt;
            rdd_r    <= rdd_nxt;
            rdv_r    <= rdv_nxt;
            err_r    <= err_nxt;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign req_ready     = (st_r == EEPC_H_IDLE);
    assign busy          = (st_r != EEPC_H_IDLE);
    assign wr_byte_index = idx_r;
    assign rd_data       = rdd_r;
    assign rd_valid      = rdv_r;
    assign timeout_err   = err_r;

    eepc_strobe u_strobe (
        .clock          (clock),
        .sys_rst        (sys_rst),
        .bus            (bus.engine),
        .chip_select_n  (chip_select_n),
        .output_drive_n (output_drive_n),
        .write_strobe_n (write_strobe_n),
        .mem_addr       (mem_addr),
        .data_pins_out  (data_pins_out),
        .data_pins_oe   (data_pins_oe),
        .data_pins_in   (data_pins_in)
    );
endmodule

// [rtl/eepc_params.svh]
// timing counts, command addresses and data for the eeprom host controller
`ifndef EEPC_PARAMS_SVH
`define EEPC_PARAMS_SVH
`define EEPC_CLK_NS         8
`define EEPC_STROBE_NS      100
`define EEPC_STROBE_CYC     ((`EEPC_STROBE_NS + `EEPC_CLK_NS - 1) / `EEPC_CLK_NS)
`define EEPC_SETUP_CYC      2
`define EEPC_BYTE_GAP_US    200
`define EEPC_BYTE_GAP_CYC   ((`EEPC_BYTE_GAP_US * 1000) / `EEPC_CLK_NS)
`define EEPC_PROG_MS        10
`define EEPC_PROG_CYC       ((`EEPC_PROG_MS * 1000000) / `EEPC_CLK_NS)
`define EEPC_READ_CYC       32
`define EEPC_ADDR_A         13'h1555
`define EEPC_ADDR_B         13'h0aaa
`define EEPC_DATA_AA        8'haa
`define EEPC_DATA_55        8'h55
`define EEPC_DATA_A0        8'ha0
`define EEPC_DATA_80        8'h80
`define EEPC_DATA_20        8'h20
`define EEPC_PAGE_BYTES     64
`endif

// [rtl/eepc_pkg.sv]
// types of the eeprom host controller
package eepc_pkg;
    typedef enum logic [1:0] {
        EEPC_OP_READ,
        EEPC_OP_WRITE,
        EEPC_OP_PROT_ON,
        EEPC_OP_PROT_OFF
    } eepc_op_type;
endpackage

// [rtl/eepc_strobe.sv]
// single asynchronous bus cycle engine driving the memory control pins
`timescale 1ns/1ns
`include "eepc_params.svh"
module eepc_strobe
    import eepc_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      sys_rst,
    eepc_bus_if.engine     bus,
    output logic           chip_select_n,
    output logic           output_drive_n,
    output logic           write_strobe_n,
    output logic [12:0]    mem_addr,
    output logic [7:0]     data_pins_out,
    output logic           data_pins_oe,
    input  wire logic [7:0] data_pins_in
);
    typedef enum logic [1:0] {EEPC_S_IDLE, EEPC_S_SETUP, EEPC_S_STROBE, EEPC_S_HOLD}
        eepc_sst_type;
    eepc_sst_type st_r, st_nxt;
    logic [7:0]   cnt_r, cnt_nxt;
    logic         wr_r, wr_nxt;
    logic [12:0]  addr_r, addr_nxt;
    logic [7:0]   wd_r, wd_nxt, rd_r, rd_nxt;
    logic         done_r, done_nxt;

    // ************************************************
    // cycle sequencing
    // ************************************************
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        wr_nxt   = wr_r;
        addr_nxt = addr_r;
        wd_nxt   = wd_r;
        rd_nxt   = rd_r;
        done_nxt = 1'b0;
        unique case (st_r)
            EEPC_S_IDLE: begin
                if (bus.start) begin
                    wr_nxt   = bus.is_write;
                    addr_nxt = bus.addr;
                    wd_nxt   = bus.wdata;
                    cnt_nxt  = 8'(`EEPC_SETUP_CYC);
                    st_nxt   = EEPC_S_SETUP;
                end
            end
            // address settles before the strobe so the late edge latches it
            EEPC_S_SETUP: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    cnt_nxt = wr_r ? 8'(`EEPC_STROBE_CYC) : 8'(`EEPC_READ_CYC);
                    st_nxt  = EEPC_S_STROBE;
                end
            end
            // strobe far wider than the noise filter so it always counts
            EEPC_S_STROBE: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    rd_nxt  = data_pins_in;
                    cnt_nxt = 8'(`EEPC_SETUP_CYC);
                    st_nxt  = EEPC_S_HOLD;
                end
            end
            // data held past the first rising edge
            EEPC_S_HOLD: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    done_nxt = 1'b1;
                    st_nxt   = EEPC_S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r   <= EEPC_S_IDLE;
            cnt_r  <= 8'h00;
            wr_r   <= 1'b0;
            addr_r <= 13'h0000;
            wd_r   <= 8'h00;
            rd_r   <= 8'h00;
            done_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            wr_r   <= wr_nxt;
            addr_r <= addr_nxt;
            wd_r   <= wd_nxt;
            rd_r   <= rd_nxt;
            done_r <= done_nxt;
        end
    end

    // ************************************************
    // pin drive
    // ************************************************
    always_comb begin
        chip_select_n  = !(st_r != EEPC_S_IDLE);
        write_strobe_n = !(wr_r && st_r == EEPC_S_STROBE);
        output_drive_n = !(!wr_r && st_r == EEPC_S_STROBE);
        data_pins_oe   = wr_r && st_r != EEPC_S_IDLE;  // never while the device drives
    end
    assign mem_addr      = addr_r;
    assign data_pins_out = wd_r;
    assign bus.done      = done_r;
    assign bus.rdata     = rd_r;
endmodule

// [sim/eepc_host_chk.sv]
// pin-level properties of the eeprom host controller
`timescale 1ns/1ns
module eepc_host_chk
    import eepc_pkg::*;
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        req_ready,
    input wire logic        busy,
    input wire logic        rd_valid,
    input wire logic        chip_select_n,
    input wire logic        output_drive_n,
    input wire logic        write_strobe_n,
    input wire logic [12:0] mem_addr,
    input wire logic [7:0]  data_pins_out,
    input wire logic        data_pins_oe
);
    // ****************************************
    // properties, all on the one clock
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_idle_after_rst: assert property ($fell(sys_rst) |-> chip_select_n && write_strobe_n
        && output_drive_n && !data_pins_oe) else $error("strobes not idle after reset");
    a_no_contend: assert property (!output_drive_n |-> !data_pins_oe && write_strobe_n)
        else $error("host drives data while output drive low");
    a_oe_needs_cs: assert property (!output_drive_n |-> !chip_select_n)
        else $error("output drive low without select");
    a_we_needs_cs: assert property (!write_strobe_n |-> !chip_select_n && data_pins_oe)
        else $error("write strobe low without select or data");
    a_addr_stable: assert property (!write_strobe_n && !$fell(write_strobe_n)
        |-> $stable(mem_addr) && $stable(data_pins_out)) else $error("address or data moved");
    a_setup_cs: assert property ($fell(write_strobe_n)
        |-> !$past(chip_select_n) && !$past(chip_select_n, 2)) else $error("select setup short");
    a_hold_cs: assert property ($rose(write_strobe_n) |-> !chip_select_n ##1 !chip_select_n)
        else $error("select hold short");
    a_strobe_width: assert property ($fell(write_strobe_n)
        |-> ##12 !write_strobe_n ##1 write_strobe_n) else $error("write strobe width wrong");
    // read data handed over four cycles after the last output drive cycle, for one cycle
    a_rd_pulse: assert property (rd_valid |-> !$past(output_drive_n, 4)
        && $past(output_drive_n, 3) ##1 !rd_valid) else $error("read valid misplaced");
    a_ready_idle: assert property (req_ready |-> !busy && chip_select_n && !data_pins_oe)
        else $error("ready while a bus cycle runs");
    c_write: cover property ($fell(write_strobe_n));
    c_read: cover property ($fell(output_drive_n));
    c_rdata: cover property (rd_valid);
endmodule
bind eepc_host eepc_host_chk eepc_host_chk_i (.clock(clock), .sys_rst(sys_rst),
    .req_ready(req_ready), .busy(busy), .rd_valid(rd_valid), .chip_select_n(chip_select_n),
    .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n), .mem_addr(mem_addr),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));

// [sim/eepc_mem_model.sv]
// behavioural page-write eeprom with polling and software protection
`timescale 1ns/1ns
module eepc_mem_model #(
    parameter int PROG_CYC = 300,
    parameter int GAP_CYC  = 2000
) (
    input  wire logic        clock,
    input  wire logic        chip_select_n,
    input  wire logic        output_drive_n,
    input  wire logic        write_strobe_n,
    input  wire logic [12:0] mem_addr,
    input  wire logic [7:0]  bus_level,
    output logic             dev_oe,
    output logic [7:0]       dev_data
);
    logic [7:0]  mem [0:8191];
    logic [12:0] ld_a[$];
    logic [7:0]  ld_d[$];
    logic [12:0] wa, last_a;
    logic [7:0]  last_d;
    logic        wr_q, prot_r;
    int          gap, prog, nprog, k, n;
    wire         wr_on = !chip_select_n && !write_strobe_n && output_drive_n;
    // ****************************************
    // power-up state
    // ****************************************
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
        prot_r = 1'b0;
        wr_q = 1'b0;
        gap = 0;
        prog = 0;
        nprog = 0;
        last_a = 13'h0000;
    end
    // ****************************************
    // page close: prefix decode, then program
    // ****************************************
    task automatic close_page;
        n = ld_a.size();
        k = 0;
        if (n > 3 && ld_a[0] == 13'h1555 && ld_d[0] == 8'haa && ld_a[1] == 13'h0aaa
            && ld_d[1] == 8'h55 && ld_a[2] == 13'h1555 && ld_d[2] == 8'ha0) k = 3;
        if (n > 6 && ld_a[0] == 13'h1555 && ld_d[0] == 8'haa && ld_a[1] == 13'h0aaa
            && ld_d[1] == 8'h55 && ld_a[2] == 13'h1555 && ld_d[2] == 8'h80
            && ld_a[3] == 13'h1555 && ld_d[3] == 8'haa && ld_a[4] == 13'h0aaa
            && ld_d[4] == 8'h55 && ld_a[5] == 13'h1555 && ld_d[5] == 8'h20) k = 6;
        if (!prot_r || k > 0) begin
            for (int i = k; i < n; i++) mem[{ld_a[k][12:6], ld_a[i][5:0]}] = ld_d[i];
            last_a = {ld_a[k][12:6], ld_a[n-1][5:0]};
            last_d = ld_d[n-1];
            prog = PROG_CYC;
            nprog = n - k;
            if (k == 3) prot_r = 1'b1;
            if (k == 6) prot_r = 1'b0;
        end
        ld_a.delete();
        ld_d.delete();
    endtask
    // sampled pins; pulses that span no rising clock edge never register
    always @(posedge clock) begin
        if (wr_on && !wr_q) wa = mem_addr;
        if (!wr_on && wr_q && prog == 0) begin
            ld_a.push_back(wa);
            ld_d.push_back(bus_level);
            gap = GAP_CYC;
        end
        wr_q = wr_on;
        if (gap > 0) gap = gap - 1;
        if (prog > 0) prog = prog - 1;
        if (ld_a.size() > 0 && (gap == 0 || (!chip_select_n && !output_drive_n))) close_page();
    end
    assign dev_oe = !chip_select_n && !output_drive_n;
    assign dev_data = (prog > 0 && mem_addr == last_a) ? ~last_d : mem[mem_addr];
endmodule

// [sim/tb_top.sv]
// self-checking bench of the eeprom host controller against the memory model
`timescale 1ns/1ns
module tb_top
    import eepc_pkg::*;
;
    logic clock = 0, sys_rst = 1, req_valid = 0, dev_oe;
    eepc_op_type req_op = EEPC_OP_READ;
    logic [12:0] req_addr = 13'h0000, mem_addr;
    logic [6:0] req_count = 7'h01;
    logic [7:0] wr_byte_data = 8'h00, rd_data, data_pins_out, dev_data, last_lvl = 8'h00, pin_lvl;
    logic [5:0] wr_byte_index;
    logic req_ready, wr_byte_take, rd_valid, busy, timeout_err, chip_select_n, output_drive_n;
    logic write_strobe_n, data_pins_oe;
    logic [7:0] wbuf [0:63];
    int err_total = 0, cmp_count = 0, cyc = 0, takes = 0;
    always #4 clock = ~clock;
    // undriven wire flips each cycle so a stale value never looks valid
    assign pin_lvl = data_pins_oe ? data_pins_out : dev_oe ? dev_data : ~last_lvl;
    always @(posedge clock) last_lvl <= pin_lvl;
    always @(negedge clock) wr_byte_data <= wbuf[wr_byte_index];
    // bytes the host has consumed, one per take pulse
    always @(posedge clock) if (wr_byte_take) takes <= takes + 1;
    eepc_host eepc_host_i (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_count(req_count),
        .wr_byte_data(wr_byte_data), .wr_byte_index(wr_byte_index), .wr_byte_take(wr_byte_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .timeout_err(timeout_err),
        .chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
        .write_strobe_n(write_strobe_n), .mem_addr(mem_addr), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .data_pins_in(pin_lvl));
    eepc_mem_model eepc_mem_model_i (.clock(clock), .chip_select_n(chip_select_n),
        .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n), .mem_addr(mem_addr),
        .bus_level(pin_lvl), .dev_oe(dev_oe), .dev_data(dev_data));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one request, then wait for its answer under a bound
    task automatic do_op(input eepc_op_type op, input logic [12:0] a, input logic [6:0] cnt);
        @(negedge clock);
        req_op = op;
        req_addr = a;
        req_count = cnt;
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        for (int i = 0; i < 20000; i++) begin
            if (op == EEPC_OP_READ ? rd_valid === 1'b1 : busy === 1'b0) break;
            @(negedge clock);
        end
        check("answer", (op == EEPC_OP_READ) ? rd_valid : !busy, 16'h0001);
        if (op != EEPC_OP_READ) check("prog left", eepc_mem_model_i.prog, 16'h0000);
        check("timeout", timeout_err, 16'h0000);
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        do_op(EEPC_OP_READ, a, 7'h01);
        check("read", rd_data, exp);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        check("idle pins", {chip_select_n, output_drive_n, write_strobe_n}, 16'h0007);
        check("idle oe", data_pins_oe, 16'h0000);
        check("idle ready", {req_ready, busy}, 16'h0002);
    endtask
    task automatic t_wrap;
        int t0;
        wbuf[62] = 8'h56;
        wbuf[63] = 8'h22;
        wbuf[0] = 8'h33;
        t0 = takes;
        do_op(EEPC_OP_WRITE, 13'h017e, 7'h03);
        check("takes", 16'(takes - t0), 16'h0003);
        check("bytes programmed", eepc_mem_model_i.nprog, 16'h0003);
        rd_chk(13'h017e, 8'h56);
        rd_chk(13'h017f, 8'h22);
        rd_chk(13'h0140, 8'h33);
        rd_chk(13'h0141, 8'hff);
    endtask
    task automatic t_full;
        for (int i = 0; i < 64; i++) wbuf[i] = 8'h5a ^ 8'(i);
        do_op(EEPC_OP_WRITE, 13'h0400, 7'h40);
        check("full page", eepc_mem_model_i.nprog, 16'h0040);
        rd_chk(13'h0400, 8'h5a);
        rd_chk(13'h043f, 8'h65);
        wbuf[0] = 8'h0f;
        do_op(EEPC_OP_WRITE, 13'h0600, 7'h00);
        check("count zero", eepc_mem_model_i.nprog, 16'h0001);
        rd_chk(13'h0600, 8'h0f);
    endtask
    task automatic t_prot;
        wbuf[0] = 8'h3c;
        do_op(EEPC_OP_PROT_ON, 13'h0800, 7'h01);
        check("prot on", eepc_mem_model_i.prot_r, 16'h0001);
        rd_chk(13'h0800, 8'h3c);
        wbuf[1] = 8'hc3;
        do_op(EEPC_OP_PROT_ON, 13'h0801, 7'h01);
        rd_chk(13'h0801, 8'hc3);
        wbuf[2] = 8'h99;
        do_op(EEPC_OP_PROT_OFF, 13'h0802, 7'h01);
        check("prot off", eepc_mem_model_i.prot_r, 16'h0000);
        rd_chk(13'h0802, 8'h99);
        wbuf[3] = 8'h77;
        do_op(EEPC_OP_WRITE, 13'h0803, 7'h01);
        rd_chk(13'h0803, 8'h77);
    endtask
    // ****************************************
    // main sequence and hang guard
    // ****************************************
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        for (int i = 0; i < 64; i++) wbuf[i] = 8'h00;
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        t_reset();
        t_wrap();
        t_full();
        t_prot();
        finish_test();
    end
endmodule
